// [rtl/drop_consts.svh]
// Constants for the drop refill compensation sequencer.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef DROP_CONSTS_SVH
`define DROP_CONSTS_SVH

`define CLK_MHZ 200
// One tenth of a millisecond, in microseconds
`define TENTH_MS_US 100
`define TICK_CYC (`TENTH_MS_US * `CLK_MHZ)
`define TICK_W 15
// One second in tenth-ms ticks
`define SEC_TICKS 10000
`define SEC_W 14
`define TIME_W 16
`define CNT_W 16
`define IDLE_W 16
`define IDLE_MAX 16'hffff
`define FMT_PULSE 1'h0
`define FMT_LEVEL 1'h1

`endif

// [rtl/drop_pkg.sv]
// Types for the drop refill compensation sequencer.
// Assumes drop_consts.svh is on the include path.
`default_nettype none
`include "drop_consts.svh"
package drop_pkg;
    typedef struct packed {
        logic [`TIME_W-1:0] refill;
        logic [`TIME_W-1:0] dwell;
        logic [`TIME_W-1:0] extra_first;
        logic [`TIME_W-1:0] extra_ext;
        logic [`TIME_W-1:0] ext_timeout_s;
        logic [`CNT_W-1:0] drop_count;
        logic trigger_format_select;
    } recipe_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_REFILL = 3'h2,
        ST_DWELL = 3'h4
    } seq_state_t;
endpackage
`default_nettype wire

// [rtl/idle_timer.sv]
// Idle-time counter in whole seconds, saturating.
// Assumes a 200 MHz clock; restart is a one-cycle pulse.
`default_nettype none
`include "drop_consts.svh"
module idle_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic restart,
    // Idle seconds
    output logic [`IDLE_W-1:0] idle_sec
);
    logic [`TICK_W-1:0] tick_ff, nxt_tick;
    logic [`SEC_W-1:0] sub_ff, nxt_sub;
    logic [`IDLE_W-1:0] sec_ff, nxt_sec;

    always_comb
    begin
        nxt_tick = tick_ff;
        nxt_sub = sub_ff;
        nxt_sec = sec_ff;
        if (restart)
        begin
            nxt_tick = '0;
            nxt_sub = '0;
            nxt_sec = '0;
        end
        else if (tick_ff == `TICK_W'(`TICK_CYC - 1))
        begin
            nxt_tick = '0;
            if (sub_ff == `SEC_W'(`SEC_TICKS - 1))
            begin
                nxt_sub = '0;
                if (sec_ff != `IDLE_MAX)
                    nxt_sec = sec_ff + `IDLE_W'(1);
            end
            else
                nxt_sub = sub_ff + `SEC_W'(1);
        end
        else
            nxt_tick = tick_ff + `TICK_W'(1);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_ff <= '0;
            sub_ff <= '0;
            sec_ff <= '0;
        end
        else
        begin
            tick_ff <= nxt_tick;
            sub_ff <= nxt_sub;
            sec_ff <= nxt_sec;
        end
    end

    assign idle_sec = sec_ff;
endmodule
`default_nettype wire

// [rtl/drop_seq.sv]
// Drop sequencer: trigger to timed jet valve pulses with first-drop
// refill compensation. Assumes recipe fields stay stable while busy.
// Times count in 0.1 ms ticks of the system clock; idle time in seconds.
`default_nettype none
`include "drop_consts.svh"
// Notes on behaviour
// - Idle below timeout adds first-drop extra
// - Idle at or above timeout adds extended extra
// - Idle time counts since last dispense
// - Pulse trigger gives programmed drop count
// - Pulse mode compensates first drop only
// - Count one means always compensated
// - Level mode dispenses while trigger held
// - Times in tenth-millisecond units, refill then dwell
// - Extended timeout is whole seconds
// - Format zero pulse, one level
module drop_seq (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Recipe settings
    input wire drop_pkg::recipe_t RECIPE,
    // Trigger from host or robot
    input wire logic TRIGGER,
    // Jet valve drive and status
    output logic VALVE_OPEN,
    output logic BUSY,
    output logic FIRST_DROP,
    output logic EXT_SELECTED
);
    drop_pkg::seq_state_t state_ff, nxt_state;
    logic [`TICK_W-1:0] tick_ff, nxt_tick;
    logic [`TIME_W:0] remain_ff, nxt_remain;
    logic [`CNT_W-1:0] left_ff, nxt_left;
    logic first_ff, nxt_first;
    logic ext_ff, nxt_ext;
    logic trig_ff, nxt_trig;

    logic nxt_valve;
    logic nxt_busy;
    logic nxt_first_out;
    logic nxt_ext_out;
    logic restart;
    logic [`IDLE_W-1:0] idle_sec;
    logic tick_end;
    logic use_ext;
    logic is_level;
    logic trig_rise;
    logic start_req;

    // Zero-extend a recipe time to the phase counter width
    function automatic logic [`TIME_W:0] phase_len(input logic [`TIME_W-1:0] t);
        phase_len = {1'h0, t};
    endfunction

    // First refill of a burst: base plus the extra picked by idle time.
    // One spare bit keeps the sum from wrapping at full-scale settings.
    function automatic logic [`TIME_W:0] first_len(
        input drop_pkg::recipe_t rcp,
        input logic ext
    );
        if (ext)
            first_len = phase_len(rcp.refill) + phase_len(rcp.extra_ext);
        else
            first_len = phase_len(rcp.refill) + phase_len(rcp.extra_first);
    endfunction

    // Shared end test for refill and dwell; a zero length still costs one
    // cycle so the valve edge is never lost
    function automatic logic phase_done(
        input logic [`TIME_W:0] remain,
        input logic last_tick
    );
        phase_done = (remain == '0) || (last_tick && remain == (`TIME_W+1)'(1));
    endfunction

    function automatic logic [`TICK_W-1:0] tick_step(
        input logic [`TICK_W-1:0] tick,
        input logic last_tick
    );
        tick_step = last_tick ? '0 : tick + `TICK_W'(1);
    endfunction

    // Idle seconds since the last drop ended
    idle_timer u_idle (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .restart(restart),
        .idle_sec(idle_sec)
    );

    assign tick_end = (tick_ff == `TICK_W'(`TICK_CYC - 1));
    // Timeout is compared in whole seconds; sub-second idle reads as zero
    assign use_ext = (idle_sec >= RECIPE.ext_timeout_s);
    assign is_level = (RECIPE.trigger_format_select == `FMT_LEVEL);
    // Pulse acts on a fresh edge only; a trigger held through a burst is
    // not taken again, so the host must release it first
    assign trig_rise = TRIGGER && !trig_ff;
    assign start_req = is_level ? TRIGGER : (trig_rise && RECIPE.drop_count != '0);

    // Burst sequencer: each drop is a refill phase then a dwell phase
    always_comb
    begin
        nxt_state = state_ff;
        nxt_tick = tick_ff;
        nxt_remain = remain_ff;
        nxt_left = left_ff;
        nxt_first = first_ff;
        nxt_ext = ext_ff;
        restart = 1'h0;
        case (state_ff)
            drop_pkg::ST_IDLE:
            begin
                nxt_tick = '0;
                // Triggers while busy are not queued: only idle looks
                if (start_req)
                begin
                    nxt_state = drop_pkg::ST_REFILL;
                    nxt_first = 1'h1;
                    // Selection is frozen for the whole burst
                    nxt_ext = use_ext;
                    nxt_left = RECIPE.drop_count;
                    nxt_remain = first_len(RECIPE, use_ext);
                end
            end
            drop_pkg::ST_REFILL:
            begin
                nxt_tick = tick_step(tick_ff, tick_end);
                if (phase_done(remain_ff, tick_end))
                begin
                    nxt_state = drop_pkg::ST_DWELL;
                    nxt_tick = '0;
                    nxt_remain = phase_len(RECIPE.dwell);
                end
                else if (tick_end)
                    nxt_remain = remain_ff - (`TIME_W+1)'(1);
            end
            drop_pkg::ST_DWELL:
            begin
                nxt_tick = tick_step(tick_ff, tick_end);
                if (phase_done(remain_ff, tick_end))
                begin
                    restart = 1'h1;
                    nxt_tick = '0;
                    nxt_first = 1'h0;
                    // Later drops use base refill only
                    nxt_remain = phase_len(RECIPE.refill);
                    // Level trigger is looked at once per drop, at dwell end,
                    // so a release mid-drop still finishes that drop
                    if (is_level)
                        nxt_state = TRIGGER ? drop_pkg::ST_REFILL : drop_pkg::ST_IDLE;
                    else if (left_ff <= `CNT_W'(1))
                        nxt_state = drop_pkg::ST_IDLE;
                    else
                    begin
                        nxt_left = left_ff - `CNT_W'(1);
                        nxt_state = drop_pkg::ST_REFILL;
                    end
                end
                else if (tick_end)
                    nxt_remain = remain_ff - (`TIME_W+1)'(1);
            end
            default:
                nxt_state = drop_pkg::ST_IDLE;
        endcase
    end

    // Sequencer state registers only
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_ff <= drop_pkg::ST_IDLE;
            tick_ff <= '0;
            remain_ff <= '0;
            left_ff <= '0;
            first_ff <= 1'h0;
            ext_ff <= 1'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            tick_ff <= nxt_tick;
            remain_ff <= nxt_remain;
            left_ff <= nxt_left;
            first_ff <= nxt_first;
            ext_ff <= nxt_ext;
        end
    end

    // Outputs are registered from the next state so they move with it
    always_comb
    begin
        nxt_trig = TRIGGER;
        nxt_valve = (nxt_state == drop_pkg::ST_REFILL);
        nxt_busy = (nxt_state != drop_pkg::ST_IDLE);
        nxt_first_out = nxt_first && nxt_busy;
        nxt_ext_out = nxt_ext;
    end

    // Every top-level output comes straight from one of these flops
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            trig_ff <= 1'h0;
            VALVE_OPEN <= 1'h0;
            BUSY <= 1'h0;
            FIRST_DROP <= 1'h0;
            EXT_SELECTED <= 1'h0;
        end
        else
        begin
            trig_ff <= nxt_trig;
            VALVE_OPEN <= nxt_valve;
            BUSY <= nxt_busy;
            FIRST_DROP <= nxt_first_out;
            EXT_SELECTED <= nxt_ext_out;
        end
    end
endmodule
`default_nettype wire

// [test/drop_seq_props.sv]
// Port checker for drop_seq.
// Assumes it is bound onto drop_seq.
`default_nettype none
`include "drop_consts.svh"
module drop_seq_props (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Inputs
    input wire drop_pkg::recipe_t RECIPE,
    input wire logic TRIGGER,
    // Outputs
    input wire logic VALVE_OPEN,
    input wire logic BUSY,
    input wire logic FIRST_DROP,
    input wire logic EXT_SELECTED
);
    logic [31:0] run_ff;
    logic [15:0] drops_ff;
    logic pulse;
    assign pulse = RECIPE.trigger_format_select == `FMT_PULSE;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    // Zero length still costs one cycle
    function automatic logic [31:0] cyc(input logic [31:0] t);
        cyc = (t == 0) ? 32'h1 : t * `TICK_CYC;
    endfunction
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            run_ff <= 32'h0;
            drops_ff <= 16'h0;
        end
        else
        begin
            run_ff <= VALVE_OPEN ? run_ff + 32'h1 : 32'h0;
            drops_ff <= !BUSY ? 16'h0 : drops_ff + 16'(VALVE_OPEN && run_ff == 0);
        end
    end
    sequence s_req;
        !BUSY && (pulse ? $rose(TRIGGER) && RECIPE.drop_count != 0 : TRIGGER);
    endsequence
    a_burst_start: assert property (s_req |=> BUSY && VALVE_OPEN && FIRST_DROP)
        else $error("burst did not start");
    a_zero_count: assert property (!BUSY && pulse && RECIPE.drop_count == 0 |=> !BUSY)
        else $error("zero count started");
    a_valve_busy: assert property (VALVE_OPEN || FIRST_DROP |-> BUSY)
        else $error("valve outside burst");
    a_ext_zero: assert property ($rose(BUSY) && RECIPE.ext_timeout_s == 0 |-> EXT_SELECTED)
        else $error("extended extra not chosen");
    a_ext_held: assert property (!$rose(BUSY) |-> $stable(EXT_SELECTED))
        else $error("selection changed mid run");
    a_first_len: assert property ($fell(VALVE_OPEN) && FIRST_DROP |-> run_ff == cyc(RECIPE.refill
        + (EXT_SELECTED ? RECIPE.extra_ext : RECIPE.extra_first)))
        else $error("first refill length wrong");
    a_later_len: assert property ($fell(VALVE_OPEN) && !FIRST_DROP |-> run_ff == cyc(RECIPE.refill))
        else $error("later refill length wrong");
    a_first_once: assert property ($rose(VALVE_OPEN) |-> FIRST_DROP == (drops_ff == 0))
        else $error("first drop flag wrong");
    a_drop_total: assert property ($fell(BUSY) && pulse |-> drops_ff == RECIPE.drop_count)
        else $error("drop count wrong");
endmodule
bind drop_seq drop_seq_props u_props (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .RECIPE(RECIPE),
    .TRIGGER(TRIGGER), .VALVE_OPEN(VALVE_OPEN), .BUSY(BUSY), .FIRST_DROP(FIRST_DROP),
    .EXT_SELECTED(EXT_SELECTED));
`default_nettype wire

// [test/drop_host.sv]
// Host or robot model driving the dispense trigger.
// Assumes the bench calls hold from one process at a time.
`default_nettype none
module drop_host (
    // Clock
    input wire logic clk,
    // Trigger
    output logic trig
);
    timeunit 1ns;
    timeprecision 1ps;
    initial trig = 1'b0;
    // Short hold acts as a pulse; long hold as a level
    task automatic hold(input int n);
        @(posedge clk);
        #1 trig = 1'b1;
        repeat (n) @(posedge clk);
        #1 trig = 1'b0;
    endtask
endmodule
`default_nettype wire

// [test/test_drop_refill_compensation_sequencer.sv]
// Bench for drop_seq: pulse, single, zero-count and level bursts.
// Assumes drop_host drives the trigger.
`default_nettype none
`include "drop_consts.svh"
module test_drop_refill_compensation_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    drop_pkg::recipe_t rcp = '0;
    logic trig, valve, busy, first, ext;
    int error_cnt = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    drop_host HOST (.clk(clk), .trig(trig));
    drop_seq DUT (.CLK_SYS(clk), .RESET_N(rst_n), .RECIPE(rcp), .TRIGGER(trig),
        .VALVE_OPEN(valve), .BUSY(busy), .FIRST_DROP(first), .EXT_SELECTED(ext));
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cfg(input logic f, input logic [15:0] c, t, xf, xe);
        @(posedge clk);
        #1 rcp = '{refill:16'h0, dwell:16'h0, extra_first:xf, extra_ext:xe,
            ext_timeout_s:t, drop_count:c, trigger_format_select:f};
    endtask
    // Counts drops and times the first refill
    task automatic run(input int hold, input int lim, output int n, output int len);
        logic was;
        int k;
        n = 0;
        len = 0;
        was = 1'b0;
        fork
            HOST.hold(hold);
        join_none
        for (k = 0; k < lim && !(n > 0 && busy === 1'b0); k++)
        begin
            @(posedge clk);
            #1;
            n += int'(valve === 1'b1 && was !== 1'b1);
            if (valve === 1'h1 && was !== 1'h1)
                check(first === (n == 1), "first drop flag");
            len += int'(valve === 1'b1 && n == 1);
            was = valve;
        end
        if (busy !== 1'b0)
        begin
            check(1'h0, "burst hung");
            print_verdict();
        end
    endtask
    task automatic t_burst();
        int n, len;
        cfg(`FMT_PULSE, 16'h3, 16'h1, 16'h1, 16'h0);
        run(2, 90000, n, len);
        check(n == 3, "pulse count");
        check(len == `TICK_CYC, "first extra");
        check(ext === 1'b0, "short idle chose extended");
    endtask
    task automatic t_single();
        int n, len;
        cfg(`FMT_PULSE, 16'h1, 16'h0, 16'h0, 16'h1);
        run(2, 90000, n, len);
        check(n == 1 && len == `TICK_CYC, "single drop");
        check(ext === 1'b1, "extended not chosen");
    endtask
    task automatic t_zero();
        int n, len;
        cfg(`FMT_PULSE, 16'h0, 16'h1, 16'h1, 16'h1);
        run(2, 20, n, len);
        check(n == 0, "zero count dispensed");
    endtask
    task automatic t_level();
        int n, len;
        cfg(`FMT_LEVEL, 16'h1, 16'h1, 16'h1, 16'h0);
        run(`TICK_CYC + 40, 90000, n, len);
        check(n > 10 && n < 30, "level train length");
        check(len == `TICK_CYC && ext === 1'b0, "level first drop");
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        t_burst();
        t_single();
        t_zero();
        t_level();
        print_verdict();
    end
endmodule
`default_nettype wire
